// *** design/smcp_array.v ***
`timescale 1ns/10ps
`default_nettype none
`include "smcp_regs.vh"

// byte array with registered read data
module smcp_array (
	input  wire                      i_sys_clk,
	input  wire                      i_wr_en,
	input  wire [`SMCP_ADDR_W-1:0]   i_addr,
	input  wire [7:0]                i_wr_data,
	output reg  [7:0]                o_rd_data
);
	reg [7:0] mem [0:`SMCP_MEM_DEPTH-1];

	always @(posedge i_sys_clk) begin
		if (i_wr_en) begin
			mem[i_addr] <= i_wr_data;
		end
		o_rd_data <= mem[i_addr];
	end
endmodule
`default_nettype wire

// *** design/smcp_regs.vh ***
`ifndef SMCP_REGS_VH
`define SMCP_REGS_VH

`define SMCP_CMD_LATCH_SET    8'h06
`define SMCP_CMD_LATCH_CLEAR  8'h04
`define SMCP_CMD_STATUS_READ  8'h05
`define SMCP_CMD_STATUS_WRITE 8'h01
`define SMCP_CMD_MEM_READ     8'h03
`define SMCP_CMD_MEM_WRITE    8'h02

`define SMCP_BIT_PIN_GUARD    7
`define SMCP_BIT_GUARD_HI     3
`define SMCP_BIT_GUARD_LO     2
`define SMCP_BIT_LATCH        1

`define SMCP_ADDR_W           15
`define SMCP_ADDR_TOP         15'h7FFF
`define SMCP_ADDR_ZERO        15'h0000
`define SMCP_QUARTER_BASE     15'h6000
`define SMCP_HALF_BASE        15'h4000
`define SMCP_GUARD_NONE       2'h0
`define SMCP_GUARD_QUARTER    2'h1
`define SMCP_GUARD_HALF       2'h2

`define SMCP_BIT_LAST         3'h7
`define SMCP_BIT_FIRST        3'h0
`define SMCP_MEM_DEPTH        32768

`endif

// *** design/smcp_top.v ***
`timescale 1ns/10ps
`default_nettype none
`include "smcp_regs.vh"

// Behaviour
// - mode chosen from clock level at select fall
// - capture input bits on rising clock
// - bytes MSB first, output changes falling clock
// - first byte is command, one per select
// - decode set, clear, status write codes
// - decode status read, memory read, write
// - latch commands bare; status commands one byte
// - latch cleared after power up
// - set command sets latch, flag reads one
// - latch clears after write or clear command
// - status write byte never loads latch flag
// - status bit layout, unused bits zero
// - block guard bits are retained
// - block guard codes select protected range
// - pin guard plus low pin blocks status
// - memory writes gated by latch, guards only
// - status read shifts out status byte
// - 15-bit address, increments, wraps
// - protect pin change applies next select
// - suspend pauses, ignores clock and select
// - select high: ignore inputs, output released
module smcp_top (
	input  wire        i_sys_clk,
	input  wire        i_reset_n,
	input  wire        i_spi_clk,
	input  wire        i_chip_sel_n,
	input  wire        i_data_in,
	input  wire        i_write_guard_n,
	input  wire        i_suspend_n,
	output reg         o_data_out,
	output reg         o_data_out_en,
	output reg  [7:0]  o_protection_status
);
	localparam ST_CMD    = 3'h0;
	localparam ST_ADDR_H = 3'h1;
	localparam ST_ADDR_L = 3'h2;
	localparam ST_DATA   = 3'h3;
	localparam ST_IDLE   = 3'h4;

	// two-flop synchronisers; only stage two feeds logic
	reg [1:0] clk_sync;
	reg [1:0] cs_sync;
	reg [1:0] din_sync;
	reg [1:0] wp_sync;
	reg [1:0] hold_sync;
	reg       clk_prev;
	reg       cs_prev;

	reg       write_latch;
	reg       pin_guard;
	reg [1:0] block_guard;
	reg       mode_idle_high;
	reg       wp_frame;
	reg [2:0] state;
	reg [7:0] cmd;
	reg [2:0] bit_cnt;
	reg [7:0] shift_in;
	reg [7:0] shift_out;
	reg [14:0] addr;
	reg       status_byte_done;
	reg [7:0] status_pending;
	reg       did_write;
	reg       out_active;
	reg       load_read;
	reg       load_wait;
	reg       out_step;
	reg       mem_we;
	reg [7:0] mem_wdata;
	reg [14:0] mem_addr;
	wire [7:0] mem_rdata;

	wire spi_clk  = clk_sync[1];
	wire cs_n     = cs_sync[1];
	wire hold_ok  = hold_sync[1];
	wire rise     = spi_clk & ~clk_prev & hold_ok;
	wire fall     = ~spi_clk & clk_prev & hold_ok;
	wire cs_fall  = ~cs_n & cs_prev & hold_ok;
	wire cs_rise  = cs_n & ~cs_prev & hold_ok;
	wire [7:0] next_byte = {shift_in[6:0], din_sync[1]};

	function [7:0] status_image;
		input       pg;
		input [1:0] bg;
		input       wl;
		begin
			status_image = 8'h00;
			status_image[`SMCP_BIT_PIN_GUARD] = pg;
			status_image[`SMCP_BIT_GUARD_HI]  = bg[1];
			status_image[`SMCP_BIT_GUARD_LO]  = bg[0];
			status_image[`SMCP_BIT_LATCH]     = wl;
		end
	endfunction

	function addr_guarded;
		input [1:0]  bg;
		input [14:0] a;
		begin
			case (bg)
			`SMCP_GUARD_NONE:    addr_guarded = 1'b0;
			`SMCP_GUARD_QUARTER: addr_guarded = (a >= `SMCP_QUARTER_BASE);
			`SMCP_GUARD_HALF:    addr_guarded = (a >= `SMCP_HALF_BASE);
			default:             addr_guarded = 1'b1;
			endcase
		end
	endfunction

	function [14:0] addr_step;
		input [14:0] a;
		begin
			addr_step = (a == `SMCP_ADDR_TOP) ? `SMCP_ADDR_ZERO : a + 15'h0001;
		end
	endfunction

	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			clk_sync  <= 2'h0;
			cs_sync   <= 2'h3;
			din_sync  <= 2'h0;
			wp_sync   <= 2'h3;
			hold_sync <= 2'h3;
			clk_prev  <= 1'b0;
			cs_prev   <= 1'b1;
		end else begin
			clk_sync  <= {clk_sync[0], i_spi_clk};
			cs_sync   <= {cs_sync[0], i_chip_sel_n};
			din_sync  <= {din_sync[0], i_data_in};
			wp_sync   <= {wp_sync[0], i_write_guard_n};
			hold_sync <= {hold_sync[0], i_suspend_n};
			if (hold_ok) begin
				clk_prev <= spi_clk;
				cs_prev  <= cs_n;
			end
		end
	end

	// guard bits held until a status write; reset stands in for power loss
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			write_latch      <= 1'b0;
			pin_guard        <= 1'b0;
			block_guard      <= 2'h0;
			mode_idle_high   <= 1'b0;
			wp_frame         <= 1'b1;
			state            <= ST_IDLE;
			cmd              <= 8'h00;
			bit_cnt          <= `SMCP_BIT_FIRST;
			shift_in         <= 8'h00;
			shift_out        <= 8'h00;
			addr             <= `SMCP_ADDR_ZERO;
			status_byte_done <= 1'b0;
			status_pending   <= 8'h00;
			did_write        <= 1'b0;
			out_active       <= 1'b0;
			load_read        <= 1'b0;
			load_wait        <= 1'b0;
			out_step         <= 1'b0;
			mem_we           <= 1'b0;
			mem_wdata        <= 8'h00;
			mem_addr         <= `SMCP_ADDR_ZERO;
		end else begin
			mem_we    <= 1'b0;
			load_read <= 1'b0;
			out_step  <= 1'b0;
			// array data lands a cycle after its address, so the load waits one more
			load_wait <= load_read;
			if (load_wait) begin
				shift_out <= mem_rdata;
			end
			if (cs_fall) begin
				mode_idle_high   <= spi_clk;
				wp_frame         <= wp_sync[1];
				state            <= ST_CMD;
				bit_cnt          <= `SMCP_BIT_FIRST;
				status_byte_done <= 1'b0;
				did_write        <= 1'b0;
				out_active       <= 1'b0;
			end else if (cs_rise) begin
				if (cmd == `SMCP_CMD_STATUS_WRITE && status_byte_done) begin
					pin_guard   <= status_pending[`SMCP_BIT_PIN_GUARD];
					block_guard <= {status_pending[`SMCP_BIT_GUARD_HI], status_pending[`SMCP_BIT_GUARD_LO]};
				end
				if (did_write || (cmd == `SMCP_CMD_STATUS_WRITE && status_byte_done)) begin
					write_latch <= 1'b0;
				end
				state      <= ST_IDLE;
				out_active <= 1'b0;
			end else if (!cs_n && rise && state != ST_IDLE) begin
				shift_in <= next_byte;
				bit_cnt  <= bit_cnt + 3'h1;
				if (bit_cnt == `SMCP_BIT_LAST) begin
					case (state)
					ST_CMD: begin
						cmd <= next_byte;
						case (next_byte)
						`SMCP_CMD_LATCH_SET: begin
							write_latch <= 1'b1;
							state       <= ST_IDLE;
						end
						`SMCP_CMD_LATCH_CLEAR: begin
							write_latch <= 1'b0;
							state       <= ST_IDLE;
						end
						`SMCP_CMD_STATUS_READ: begin
							shift_out <= status_image(pin_guard, block_guard, write_latch);
							state     <= ST_DATA;
						end
						// status write needs latch, and pin high if pin guard set
						`SMCP_CMD_STATUS_WRITE: begin
							if (write_latch && !(pin_guard && !wp_frame)) begin
								state <= ST_DATA;
							end else begin
								state <= ST_IDLE;
							end
						end
						`SMCP_CMD_MEM_READ, `SMCP_CMD_MEM_WRITE: begin
							state <= ST_ADDR_H;
						end
						default: begin
							state <= ST_IDLE;
						end
						endcase
					end
					ST_ADDR_H: begin
						addr[14:8] <= next_byte[6:0];
						state      <= ST_ADDR_L;
					end
					ST_ADDR_L: begin
						addr[7:0] <= next_byte;
						mem_addr  <= {addr[14:8], next_byte};
						state     <= ST_DATA;
						load_read <= (cmd == `SMCP_CMD_MEM_READ);
					end
					ST_DATA: begin
						if (cmd == `SMCP_CMD_STATUS_WRITE) begin
							// latch flag kept; one byte only
							status_pending   <= next_byte;
							status_byte_done <= 1'b1;
							state            <= ST_IDLE;
						end else if (cmd == `SMCP_CMD_STATUS_READ) begin
							state <= ST_IDLE;
						end else begin
							if (cmd == `SMCP_CMD_MEM_WRITE && write_latch) begin
								did_write <= 1'b1;
								if (!addr_guarded(block_guard, addr)) begin
									mem_we    <= 1'b1;
									mem_wdata <= next_byte;
									mem_addr  <= addr;
								end
							end else begin
								mem_addr  <= addr_step(addr);
								load_read <= 1'b1;
							end
							addr <= addr_step(addr);
						end
					end
					default: state <= ST_IDLE;
					endcase
				end
			end else if (!cs_n && fall && state == ST_DATA &&
			             (cmd == `SMCP_CMD_STATUS_READ || cmd == `SMCP_CMD_MEM_READ)) begin
				// output shifts on falling edge, MSB first
				out_active <= 1'b1;
				out_step   <= 1'b1;
				// a freshly loaded byte already has its MSB in place
				if (bit_cnt != `SMCP_BIT_FIRST) begin
					shift_out <= {shift_out[6:0], 1'b0};
				end
			end
			if (mem_we) begin
				mem_addr <= addr;
			end
		end
	end

	// output released while select high or suspended
	always @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_data_out          <= 1'b0;
			o_data_out_en       <= 1'b0;
			o_protection_status <= 8'h00;
		end else begin
			// pin moves only after a falling edge, never when a byte is loaded
			if (out_step) begin
				o_data_out <= shift_out[7];
			end
			o_data_out_en       <= out_active & ~cs_n & hold_ok;
			o_protection_status <= status_image(pin_guard, block_guard, write_latch);
		end
	end

	smcp_array u_array (
		.i_sys_clk (i_sys_clk),
		.i_wr_en   (mem_we),
		.i_addr    (mem_addr),
		.i_wr_data (mem_wdata),
		.o_rd_data (mem_rdata)
	);
endmodule
`default_nettype wire

// *** verif/smcp_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module smcp_host_model (
	input  wire logic i_sys_clk,
	input  wire logic i_miso,
	output var  logic o_sck,
	output var  logic o_cs_n,
	output var  logic o_mosi,
	output var  logic o_hold_n
);
	logic mode3;
	initial begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
		o_hold_n = 1'b1;
		mode3 = 1'b0;
	end
	// half period of four system clocks keeps the synchroniser in step
	task automatic wait_half();
		repeat (4) @(negedge i_sys_clk);
	endtask
	// idle level settles before select falls; xfer lowers the clock
	task automatic open_frame(input logic m3);
		mode3 = m3;
		@(negedge i_sys_clk);
		o_sck = m3;
		wait_half();
		o_cs_n = 1'b0;
		wait_half();
	endtask
	// bit placed with the falling edge, read back before the next one
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			@(negedge i_sys_clk);
			o_sck = 1'b0;
			o_mosi = tx[i];
			wait_half();
			o_sck = 1'b1;
			wait_half();
			rx[i] = i_miso;
		end
	endtask
	// suspend moves only while the clock is low
	task automatic hold_enter();
		@(negedge i_sys_clk);
		o_sck = 1'b0;
		wait_half();
		o_hold_n = 1'b0;
		wait_half();
	endtask
	// clock pulses inside the pause must leave no trace
	task automatic hold_leave(input int pulses);
		repeat (pulses) begin
			o_sck = 1'b1;
			wait_half();
			o_sck = 1'b0;
			wait_half();
		end
		o_hold_n = 1'b1;
		wait_half();
	endtask
	// mode 3 leaves the clock high after the last rising edge
	task automatic close_frame();
		wait_half();
		o_mosi = ~o_mosi;
		o_sck = mode3;
		wait_half();
		o_cs_n = 1'b1;
		wait_half();
		wait_half();
	endtask
endmodule
`default_nettype wire

// *** verif/smcp_top_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
module smcp_top_monitor (
	input wire logic       i_sys_clk,
	input wire logic       i_reset_n,
	input wire logic       i_spi_clk,
	input wire logic       i_chip_sel_n,
	input wire logic       i_data_in,
	input wire logic       i_write_guard_n,
	input wire logic       i_suspend_n,
	input wire logic       o_data_out,
	input wire logic       o_data_out_en,
	input wire logic [7:0] o_protection_status
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	wire [2:0] guards = {o_protection_status[7], o_protection_status[3:2]};
	// select seen high long enough to pass the synchroniser
	sequence s_sel_quiet;
		i_chip_sel_n [*6];
	endsequence
	sequence s_en_rise;
		!o_data_out_en ##1 o_data_out_en;
	endsequence
	a_reset_clear: assert property (disable iff (1'b0) !i_reset_n |=> o_protection_status == 8'h00 && !o_data_out_en)
		else $error("reset left status or enable set");
	a_fixed_zero: assert property (o_protection_status[6:4] == 3'h0 && !o_protection_status[0])
		else $error("fixed status bit not zero");
	a_sel_release: assert property (s_sel_quiet |-> !o_data_out_en)
		else $error("output driven while deselected");
	a_latch_quiet: assert property (s_sel_quiet ##0 !o_protection_status[1] |=> !o_protection_status[1])
		else $error("latch set outside a frame");
	a_latch_in_frame: assert property ($rose(o_protection_status[1]) |-> !$past(i_chip_sel_n, 4))
		else $error("latch rose without select");
	a_guard_commit: assert property (!$stable(guards) |-> i_chip_sel_n && $past(i_chip_sel_n, 2))
		else $error("guard bits changed inside a frame");
	a_out_falling: assert property (o_data_out_en && $past(o_data_out_en) && !$stable(o_data_out) |-> !$past(i_spi_clk, 3))
		else $error("output bit changed off a falling edge");
	a_en_in_frame: assert property (s_en_rise |-> !i_chip_sel_n && !$past(i_chip_sel_n, 3))
		else $error("output enabled without select");
	a_hold_release: assert property (!i_suspend_n [*4] |-> !o_data_out_en)
		else $error("output driven while suspended");
endmodule
bind smcp_top smcp_top_monitor u_smcp_mon (.i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_spi_clk(i_spi_clk),
	.i_chip_sel_n(i_chip_sel_n), .i_data_in(i_data_in), .i_write_guard_n(i_write_guard_n),
	.i_suspend_n(i_suspend_n), .o_data_out(o_data_out), .o_data_out_en(o_data_out_en),
	.o_protection_status(o_protection_status));
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic            clk;
	logic            rst_n;
	logic            guard_n;
	logic            miso_q;
	logic [7:0]      rxb [0:4];
	int              err_total;
	int              checked;
	wire logic       sck;
	wire logic       cs_n;
	wire logic       mosi;
	wire logic       hold_n;
	wire logic       dout;
	wire logic       dout_en;
	wire logic       miso;
	wire logic [7:0] status;
	initial clk = 1'b0;
	always #12.5 clk = ~clk;
	// released line toggles so a stale bit never passes
	always @(posedge clk) miso_q <= rst_n ? miso : 1'b0;
	assign miso = dout_en ? dout : ~miso_q;
	smcp_host_model host (.i_sys_clk(clk), .i_miso(miso), .o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi),
		.o_hold_n(hold_n));
	smcp_top dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_spi_clk(sck), .i_chip_sel_n(cs_n), .i_data_in(mosi),
		.i_write_guard_n(guard_n), .i_suspend_n(hold_n), .o_data_out(dout), .o_data_out_en(dout_en),
		.o_protection_status(status));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic frame(input int n, input logic [7:0] b0, b1 = 8'h00, b2 = 8'h00, b3 = 8'h00,
		b4 = 8'h00, input logic m3 = 1'b0);
		logic [7:0] tx [0:4];
		tx = '{b0, b1, b2, b3, b4};
		host.open_frame(m3);
		for (int i = 0; i < n; i++) begin
			host.xfer(tx[i], rxb[i]);
		end
		host.close_frame();
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic t_latch();
		check(status, 8'h00);
		frame(1, 8'h06);
		check(status, 8'h02);
		frame(2, 8'h05);
		check(rxb[1], 8'h02);
		frame(1, 8'h04);
		check(status, 8'h00);
	endtask
	task automatic t_status_write();
		frame(2, 8'h01, 8'hFF);
		check(status, 8'h00);
		frame(1, 8'h06);
		frame(2, 8'h01, 8'hFF);
		check(status, 8'h8C);
		frame(2, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1);
		check(rxb[1], 8'h8C);
	endtask
	task automatic t_pin_guard();
		guard_n = 1'b0;
		frame(1, 8'h06);
		frame(2, 8'h01, 8'h00);
		check(status & 8'hFD, 8'h8C);
		guard_n = 1'b1;
		frame(1, 8'h06);
		host.open_frame(1'b0);
		// pin drops after select fall: this write must still land
		guard_n = 1'b0;
		host.xfer(8'h01, rxb[0]);
		host.xfer(8'h00, rxb[1]);
		host.close_frame();
		check(status, 8'h00);
	endtask
	task automatic t_memory();
		frame(1, 8'h06);
		frame(5, 8'h02, 8'hFF, 8'hFF, 8'h11, 8'h22);
		check(status, 8'h00);
		guard_n = 1'b0;
		frame(1, 8'h06);
		frame(2, 8'h01, 8'h04);
		check(status, 8'h04);
		frame(1, 8'h06);
		frame(5, 8'h02, 8'h7F, 8'hFF, 8'h33, 8'h66);
		frame(5, 8'h03, 8'h7F, 8'hFF);
		check(rxb[3], 8'h11);
		check(rxb[4], 8'h66);
	endtask
	task automatic t_unknown();
		frame(2, 8'hFF, 8'h06);
		check(status, 8'h04);
	endtask
	task automatic t_suspend();
		host.open_frame(1'b0);
		host.xfer(8'h05, rxb[0]);
		host.hold_enter();
		check({7'h00, dout_en}, 8'h00);
		host.hold_leave(3);
		check({7'h00, dout_en}, 8'h01);
		host.xfer(8'h00, rxb[1]);
		host.close_frame();
		check(rxb[1], 8'h04);
		check({7'h00, dout_en}, 8'h00);
	endtask
	initial begin
		rst_n = 1'b0;
		guard_n = 1'b1;
		err_total = 0;
		checked = 0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_latch();
		t_status_write();
		t_pin_guard();
		t_memory();
		t_unknown();
		t_suspend();
		final_report();
	end
	initial begin
		#2000000;
		err_total++;
		final_report();
	end
endmodule
`default_nettype wire
